/* core/fpx_unit.sv */
// floating-point add, compare and divide unit with its register port
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Contract
// - add checks both sources for reserved encodings, then adds and writes sum
// - reserved source operand takes reserved operand exception, no result
// - add and divide signal overflow, underflow or inexact from the result
// - inexact is raised only when not masked
// - each source and destination precision chosen independently
// - destination register zero or unit disabled takes unimplemented exception
// - precision code 00 is single, 01 is double
// - add word: opcode 100001, sub-op 00101, fields at documented bits
// - compare word: sub-op 00111, bits 6-5 zero, two source precisions
// - compare evaluates relations of first minus second, writes bit string
// - compare gives four range-bound flags of first against zero..second
// - negative second operand clears all four range-bound flags
// - signed relation flags set exactly when the relation holds
// - ordered flag set when ordered, unordered flag when unordered
// - compare result bits above the flags are zero
// - divide puts first over second quotient in the destination
// - zero divisor raises divide-by-zero
module fpx_unit
    import fpx_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // issue from the sequencer
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [63:0] src_a_data,
    input wire logic [63:0] src_b_data,
    // completion towards the register file
    output logic busy,
    output logic done,
    output logic wr_en,
    output logic [4:0] wr_reg,
    output logic wr_double,
    output logic [63:0] wr_data,
    output logic [5:0] exc_taken,
    // interrupt
    output logic irq
);
    // ========================================================
    // unpack: {reserved, zero, sign, unbiased exp[12:0], mantissa[52:0]}
    function automatic logic [68:0] fpx_unpack(input logic [63:0] d, input logic dbl);
        logic [10:0] e;
        logic [51:0] f;
        logic [12:0] ue;
        logic s;
        logic rsv;
        begin
            if (dbl)
            begin
                s = d[63];
                e = d[62:52];
                f = d[51:0];
                ue = 13'(e) - 13'(DBL_BIAS);
                rsv = (e == 11'h7ff) || (e == 11'h000 && f != 52'h0);
            end
            else
            begin
                s = d[31];
                e = {3'h0, d[30:23]};
                f = {d[22:0], 29'h0};
                ue = 13'(e) - 13'(SGL_BIAS);
                rsv = (e == 11'h0ff) || (e == 11'h000 && f != 52'h0);
            end
            return {rsv, (e == 11'h000 && f == 52'h0), s, ue, 1'b1, f};
        end
    endfunction

    // ========================================================
    // state and registers
    fpx_state_e state_r, state_nxt;
    logic [1:0] ctrl_r;
    logic [5:0] stat_r, stat_nxt;
    logic [5:0] mask_r, mask_nxt;
    logic [31:0] rdata_r;
    logic busy_r, done_r, we_r, wdbl_r, irq_r;
    logic [4:0] wreg_r, dst_r;
    logic [63:0] wdata_r;
    logic [5:0] exc_r;
    logic raw_s_r, raw_dbl_r;
    logic [12:0] raw_e_r;
    logic [56:0] raw_m_r;
    logic [54:0] rem_r;
    logic [52:0] dvs_r;
    logic [5:0] cnt_r;

    // ========================================================
    // instruction decode
    wire [5:0] d_opc = issue_instr[OPC_HI:OPC_LO];
    wire [4:0] d_sub = issue_instr[SUB_HI:SUB_LO];
    wire [4:0] d_dst = issue_instr[DST_HI:DST_LO];
    wire [1:0] d_ta = issue_instr[TA_HI:TA_LO];
    wire [1:0] d_tb = issue_instr[TB_HI:TB_LO];
    wire [1:0] d_td = issue_instr[TD_HI:TD_LO];
    wire op_add = d_opc == FPX_OPC && d_sub == FPX_SUB_ADD;
    wire op_cmp = d_opc == FPX_OPC && d_sub == FPX_SUB_CMP;
    wire op_div = d_opc == FPX_OPC && d_sub == FPX_SUB_DIV;
    // precision codes: only single and double are legal
    wire ta_ok = d_ta == PREC_SGL || d_ta == PREC_DBL;
    wire tb_ok = d_tb == PREC_SGL || d_tb == PREC_DBL;
    wire td_ok = op_cmp ? d_td == 2'h0 : (d_td == PREC_SGL || d_td == PREC_DBL);
    wire bad_word = !(op_add || op_cmp || op_div) || !ta_ok || !tb_ok || !td_ok;
    wire unimp = !ctrl_r[CTRL_EN_BIT] || d_dst == 5'h00 || bad_word;

    // operand unpack, each by its own precision field
    wire [68:0] ua = fpx_unpack(src_a_data, d_ta == PREC_DBL);
    wire [68:0] ub = fpx_unpack(src_b_data, d_tb == PREC_DBL);
    wire a_rsv = ua[68];
    wire a_zer = ua[67];
    wire a_s = ua[66];
    wire [12:0] a_x = ua[65:53];
    wire [52:0] a_m = ua[52:0];
    wire b_rsv = ub[68];
    wire b_zer = ub[67];
    wire b_s = ub[66];
    wire [12:0] b_x = ub[65:53];
    wire [52:0] b_m = ub[52:0];
    wire rsv_hit = a_rsv || b_rsv;
    wire dz_hit = op_div && b_zer;

    // magnitude keys: zero maps to the smallest key
    wire [12:0] a_e = a_zer ? 13'h1000 : a_x;
    wire [12:0] b_e = b_zer ? 13'h1000 : b_x;
    wire [65:0] ka = a_zer ? 66'h0 : {a_e ^ 13'h1000, a_m};
    wire [65:0] kb = b_zer ? 66'h0 : {b_e ^ 13'h1000, b_m};
    wire a_big = ka >= kb;

    // ========================================================
    // add alignment and sum
    wire [12:0] e_big = a_big ? a_e : b_e;
    wire [12:0] e_dif = a_big ? a_e - b_e : b_e - a_e;
    wire [55:0] m_big = a_big ? {a_m & {53{!a_zer}}, 3'h0} : {b_m & {53{!b_zer}}, 3'h0};
    wire [55:0] m_sml = a_big ? {b_m & {53{!b_zer}}, 3'h0} : {a_m & {53{!a_zer}}, 3'h0};
    wire [55:0] m_shr = m_sml >> e_dif;
    wire m_lost = |(m_sml ^ (m_shr << e_dif)); // bits shifted out fold into sticky
    wire [56:0] m_aln = {1'b0, m_shr[55:1], m_shr[0] | m_lost};
    wire eff_sub = a_s ^ b_s;
    wire [56:0] add_sum = eff_sub ? {1'b0, m_big} - m_aln : {1'b0, m_big} + m_aln;
    wire add_sgn = (add_sum == 57'h0) ? (a_s & b_s) : (a_big ? a_s : b_s);

    // ========================================================
    // compare relations on signed values
    wire na = a_s && !a_zer;
    wire nb = b_s && !b_zer;
    wire c_eq = ka == kb && na == nb;
    wire c_lt = (na && !nb) || (!na && !nb && ka < kb) || (na && nb && ka > kb);
    wire c_gt = !c_lt && !c_eq;
    // range-bound flags against zero .. second operand
    wire r_in = !nb && !na && ka != 66'h0 && c_lt;
    wire r_ib = !nb && !na && (c_lt || c_eq);
    wire r_ou = !nb && (na || c_gt);
    wire r_ob = !nb && (na || ka == 66'h0 || c_gt || c_eq);
    // operands that pass the reserved check are always ordered
    wire c_ord = !rsv_hit;
    wire [31:0] cmp_word = {20'h0,
        r_ob, r_in, r_ib, r_ou,
        !c_lt, c_lt, c_lt || c_eq, c_gt, !c_eq, c_eq,
        c_ord, !c_ord};

    // ========================================================
    // issue-time completion: exceptions by priority, or compare
    wire [5:0] early_exc = unimp ? EXC_UNIMP : rsv_hit ? EXC_RSV : dz_hit ? EXC_DZ : 6'h00;
    wire take = state_r == FPX_IDLE && issue_valid;
    wire early_fin = take && (early_exc != 6'h00 || op_cmp);
    wire start_add = take && !early_fin && op_add;
    wire start_div = take && !early_fin && op_div;

    // ========================================================
    // normalise and round the raw result
    wire [56:0] rnd_m = raw_m_r | {56'h0, rem_r != 55'h0}; // remainder is divide sticky
    logic [5:0] lead;
    always_comb
    begin
        lead = 6'h00;
        for (int i = 0; i < 57; i++)
            if (rnd_m[i])
                lead = 6'(i);
    end
    wire top_hit = lead == 6'(MANT_TOP + 1);
    wire [5:0] lsh = top_hit ? 6'h00 : 6'(MANT_TOP) - lead;
    wire [55:0] nm = top_hit ? {rnd_m[56:2], rnd_m[1] | rnd_m[0]} : rnd_m[55:0] << lsh;
    wire [12:0] ne = top_hit ? raw_e_r + 13'h0001 : raw_e_r - {7'h00, lsh};
    wire [5:0] drop = raw_dbl_r ? DROP_DBL : DROP_SGL;
    wire [52:0] kept = 53'(nm >> drop);
    wire g_bit = nm[6'(drop - 6'h01)];
    wire [55:0] s_msk = (56'h1 << (drop - 6'h01)) - 56'h1;
    wire s_bit = |(nm & s_msk);
    wire up = g_bit & (s_bit | kept[0]); // round to nearest even
    wire [53:0] rk = {1'b0, kept} + 54'(up);
    wire carry = raw_dbl_r ? rk[53] : rk[24];
    wire [12:0] bias = raw_dbl_r ? 13'(DBL_BIAS) : 13'(SGL_BIAS);
    wire [12:0] emax = raw_dbl_r ? 13'(DBL_EMAX) : 13'(SGL_EMAX);
    wire [12:0] bexp = ne + 13'(carry) + bias;
    wire nz = rnd_m != 57'h0;
    wire ovf = nz && $signed(bexp) >= $signed(emax);
    wire unf = nz && $signed(bexp) <= $signed(13'h0000);
    wire inx = nz && (g_bit || s_bit);
    wire inx_take = inx && !ctrl_r[CTRL_IXM_BIT];
    wire [5:0] rnd_exc = ovf ? EXC_OVF : unf ? EXC_UNF : inx_take ? EXC_INX : 6'h00;
    wire [63:0] pk_dbl = nz ? {raw_s_r, bexp[10:0], rk[51:0]} : {raw_s_r, 63'h0};
    wire [31:0] pk_sgl = nz ? {raw_s_r, bexp[7:0], rk[22:0]} : {raw_s_r, 31'h0};
    wire [63:0] rnd_res = raw_dbl_r ? pk_dbl : {32'h0, pk_sgl};

    // ========================================================
    // divide step: restoring, one quotient bit per cycle
    wire dv_ge = rem_r >= {2'h0, dvs_r};
    wire [54:0] dv_sub = dv_ge ? rem_r - {2'h0, dvs_r} : rem_r;
    wire [54:0] dv_rem = {dv_sub[53:0], 1'b0};

    // ========================================================
    // finish selection shared by both completion paths
    wire rnd_fin = state_r == FPX_RND;
    wire fin = early_fin || rnd_fin;
    wire [5:0] fin_exc = rnd_fin ? rnd_exc : early_exc;
    wire fin_we = fin && fin_exc == 6'h00;
    wire [63:0] fin_data = rnd_fin ? rnd_res : {32'h0, cmp_word};
    wire fin_dbl = rnd_fin && raw_dbl_r;
    wire [4:0] fin_reg = rnd_fin ? dst_r : d_dst;

    // state sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            FPX_IDLE:
            begin
                if (start_add)
                    state_nxt = FPX_RND;
                else if (start_div)
                    state_nxt = FPX_DIV;
            end
            FPX_DIV:
            begin
                if (cnt_r == 6'h01)
                    state_nxt = FPX_RND;
            end
            FPX_RND:
                state_nxt = FPX_IDLE;
            default:
                state_nxt = FPX_IDLE;
        endcase
    end

    // ========================================================
    // register port decode
    wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    wire wr_stat = reg_wr && reg_addr == REG_STAT;
    wire wr_mask = reg_wr && reg_addr == REG_MASK;
    wire [5:0] stat_set = fin ? fin_exc : 6'h00;
    wire [5:0] stat_clr = wr_stat ? reg_wdata[5:0] : 6'h00;
    assign stat_nxt = (stat_r & ~stat_clr) | stat_set; // a new event beats the clear
    assign mask_nxt = wr_mask ? reg_wdata[5:0] : mask_r;
    wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {30'h0, ctrl_r} :
                         (reg_addr == REG_STAT) ? {26'h0, stat_r} :
                         (reg_addr == REG_MASK) ? {26'h0, mask_r} :
                         (reg_addr == REG_INFO) ? {24'h0, cnt_r, state_r} : 32'h0;

    // control and interrupt registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RST;
            stat_r <= STAT_RST;
            mask_r <= MASK_RST;
            irq_r <= 1'b0;
            rdata_r <= 32'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= reg_wdata[1:0];
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= |(stat_nxt & mask_nxt);
            rdata_r <= reg_rd ? rd_mux : 32'h0; // data stands one cycle only
        end
    end

    // sequencer state and datapath holding registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= FPX_IDLE;
            cnt_r <= 6'h00;
            raw_s_r <= 1'b0;
            raw_e_r <= 13'h0000;
            raw_m_r <= 57'h0;
            raw_dbl_r <= 1'b0;
            rem_r <= 55'h0;
            dvs_r <= 53'h0;
            dst_r <= 5'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (start_add)
            begin
                raw_s_r <= add_sgn;
                raw_e_r <= e_big;
                raw_m_r <= add_sum;
                rem_r <= 55'h0;
            end
            else if (start_div)
            begin
                raw_s_r <= a_s ^ b_s;
                raw_e_r <= a_x - b_x;
                raw_m_r <= a_zer ? 57'h0 : 57'h0;
                rem_r <= a_zer ? 55'h0 : {2'h0, a_m};
                dvs_r <= b_m;
                cnt_r <= DIV_STEPS;
            end
            else if (state_r == FPX_DIV)
            begin
                raw_m_r <= {raw_m_r[55:0], dv_ge};
                rem_r <= dv_rem;
                cnt_r <= cnt_r - 6'h01;
            end
            if (start_add || start_div)
            begin
                raw_dbl_r <= d_td == PREC_DBL;
                dst_r <= d_dst;
            end
        end
    end

    // completion outputs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            we_r <= 1'b0;
            wreg_r <= 5'h00;
            wdbl_r <= 1'b0;
            wdata_r <= 64'h0;
            exc_r <= 6'h00;
        end
        else
        begin
            busy_r <= state_nxt != FPX_IDLE;
            done_r <= fin;
            we_r <= fin_we;
            if (fin)
            begin
                wreg_r <= fin_reg;
                wdbl_r <= fin_dbl;
                wdata_r <= fin_data;
                exc_r <= fin_exc;
            end
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign busy = busy_r;
    assign done = done_r;
    assign wr_en = we_r;
    assign wr_reg = wreg_r;
    assign wr_double = wdbl_r;
    assign wr_data = wdata_r;
    assign exc_taken = exc_r;
    assign irq = irq_r;
endmodule // fpx_unit

/* core/fpx_pkg.sv */
// constants, field layout and types of the floating-point add, compare and divide unit
package fpx_pkg;
    // ========================================================
    // instruction word fields
    localparam logic [5:0] FPX_OPC = 6'h21;
    localparam logic [4:0] FPX_SUB_ADD = 5'h05;
    localparam logic [4:0] FPX_SUB_CMP = 5'h07;
    localparam logic [4:0] FPX_SUB_DIV = 5'h0e;
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int DST_HI = 25;
    localparam int DST_LO = 21;
    localparam int SRA_HI = 20;
    localparam int SRA_LO = 16;
    localparam int SUB_HI = 15;
    localparam int SUB_LO = 11;
    localparam int TA_HI = 10;
    localparam int TA_LO = 9;
    localparam int TB_HI = 8;
    localparam int TB_LO = 7;
    localparam int TD_HI = 6;
    localparam int TD_LO = 5;
    localparam int SRB_HI = 4;
    localparam int SRB_LO = 0;
    localparam logic [1:0] PREC_SGL = 2'h0;
    localparam logic [1:0] PREC_DBL = 2'h1;
    // ========================================================
    // number formats and datapath
    localparam int SGL_BIAS = 127;
    localparam int DBL_BIAS = 1023;
    localparam int SGL_EMAX = 255;
    localparam int DBL_EMAX = 2047;
    localparam int MANT_TOP = 55;
    localparam logic [5:0] DROP_SGL = 6'h20;
    localparam logic [5:0] DROP_DBL = 6'h03;
    localparam logic [5:0] DIV_STEPS = 6'h38;
    // ========================================================
    // exception vector, one hot
    localparam logic [5:0] EXC_UNIMP = 6'h01;
    localparam logic [5:0] EXC_RSV = 6'h02;
    localparam logic [5:0] EXC_DZ = 6'h04;
    localparam logic [5:0] EXC_OVF = 6'h08;
    localparam logic [5:0] EXC_UNF = 6'h10;
    localparam logic [5:0] EXC_INX = 6'h20;
    // ========================================================
    // register map and reset values
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_INFO = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_IXM_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [5:0] STAT_RST = 6'h00;
    localparam logic [5:0] MASK_RST = 6'h00;
    // ========================================================
    // sequencing
    typedef enum logic [1:0] {
        FPX_IDLE = 2'b00,
        FPX_DIV = 2'b01,
        FPX_RND = 2'b10
    } fpx_state_e;
endpackage

/* core/fpx_placeholder_note.sv */
// intentionally empty companion file holding no logic
`timescale 1ns/1ns

/* tb/fpx_unit_props.sv */
// concurrent checks on the ports of the add, compare and divide unit
`timescale 1ns/1ns
module fpx_unit_props
    import fpx_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // issue side
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [63:0] src_b_data,
    // completion side
    input wire logic busy,
    input wire logic done,
    input wire logic wr_en,
    input wire logic wr_double,
    input wire logic [63:0] wr_data,
    input wire logic [5:0] exc_taken
);
    // ========================================================
    // helper: instruction taken and what it was
    logic take_w;
    logic [4:0] sub_w;
    logic negb_w;
    logic [4:0] sub_r;
    logic negb_r;
    assign take_w = issue_valid && !busy;
    assign sub_w = issue_instr[SUB_HI:SUB_LO];
    assign negb_w = (issue_instr[TB_HI:TB_LO] == PREC_DBL) ? (src_b_data[63] && |src_b_data[62:0])
                    : (src_b_data[31] && |src_b_data[30:0]);
    // operation kept until its done
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sub_r <= 5'h00;
            negb_r <= 1'b0;
        end
        else if (take_w)
        begin
            sub_r <= sub_w;
            negb_r <= negb_w;
        end
    end
    // ========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_write_ok_only: assert property (wr_en |-> done && exc_taken == 6'h00)
        else $error("write pulse without clean completion");
    chk_exc_one_hot: assert property (done |-> $onehot0(exc_taken))
        else $error("more than one exception reported");
    chk_unimp_dest: assert property (take_w && issue_instr[DST_HI:DST_LO] == 5'h00 |=>
        done && exc_taken == EXC_UNIMP && !wr_en)
        else $error("destination zero not refused as unimplemented");
    chk_cmp_latency: assert property (take_w && sub_w == FPX_SUB_CMP |=> done)
        else $error("compare did not complete in one cycle");
    chk_add_latency: assert property (take_w && sub_w == FPX_SUB_ADD |=>
        (done && exc_taken != 6'h00) or (busy ##1 done))
        else $error("add completion timing wrong");
    chk_div_bound: assert property (take_w && sub_w == FPX_SUB_DIV |-> ##[1:58] done)
        else $error("divide did not complete in time");
    chk_cmp_upper_zero: assert property (done && wr_en && sub_r == FPX_SUB_CMP |->
        wr_data[63:12] == 52'h0 && wr_data[1:0] == 2'b10 && !wr_double)
        else $error("compare result upper bits or order flags wrong");
    chk_cmp_relations: assert property (done && wr_en && sub_r == FPX_SUB_CMP |->
        wr_data[7] != wr_data[6] && wr_data[5] != wr_data[4] && wr_data[3] != wr_data[2]
        && wr_data[7] == (wr_data[4] | wr_data[2]))
        else $error("compare relation flags inconsistent");
    chk_neg_bounds: assert property (done && wr_en && sub_r == FPX_SUB_CMP && negb_r |->
        wr_data[11:8] == 4'h0)
        else $error("range flags set with negative bound");
endmodule // fpx_unit_props

/* tb/fpx_seq_model.sv */
// register file and operand fetch standing in for the instruction sequencer
`timescale 1ns/1ns
module fpx_seq_model
    import fpx_pkg::*;
(
    // clock
    input wire logic mclk,
    // instruction on offer
    input wire logic [31:0] issue_instr,
    // completion from the unit
    input wire logic wr_en,
    input wire logic [4:0] wr_reg,
    input wire logic [63:0] wr_data,
    // operands towards the unit
    output logic [63:0] src_a_data,
    output logic [63:0] src_b_data
);
    logic [63:0] rf [32];
    // operands follow the source fields of the offered word
    assign src_a_data = rf[issue_instr[SRA_HI:SRA_LO]];
    assign src_b_data = rf[issue_instr[SRB_HI:SRB_LO]];
    // results land on the edge carrying the write pulse
    always @(posedge mclk)
    begin
        if (wr_en)
        begin
            rf[wr_reg] <= wr_data;
        end
    end
endmodule // fpx_seq_model

/* tb/testbench.sv */
// self-checking bench for the add, compare and divide unit
`timescale 1ns/1ns
module testbench;
    import fpx_pkg::*;
    // ========================================================
    // signals
    logic mclk = 1'b0;
    logic rst, reg_wr, reg_rd, issue_valid, busy, done, wr_en, wr_double, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, issue_instr;
    logic [63:0] src_a_data, src_b_data, wr_data;
    logic [4:0] wr_reg;
    logic [5:0] exc_taken;
    int num_errors = 0;
    int checks_done = 0;
    localparam logic [63:0] MARK = 64'h5a5a_5a5a_5a5a_5a5a;
    localparam logic [63:0] ONE = 64'h0000_0000_3f80_0000, TWO = 64'h0000_0000_4000_0000;
    localparam logic [63:0] INF = 64'h0000_0000_7f80_0000, ZRO = 64'h0;
    logic [31:0] cmp_a [6] = '{32'h3f80_0000, 32'h4000_0000, 32'h4000_0000, 32'h3f80_0000,
        32'h0000_0000, 32'hbf80_0000};
    logic [31:0] cmp_b [6] = '{32'h4000_0000, 32'h3f80_0000, 32'h4000_0000, 32'hbf80_0000,
        32'h8000_0000, 32'h4000_0000};
    logic [11:0] cmp_f [6] = '{12'h66a, 12'h99a, 12'haa6, 12'h09a, 12'haa6, 12'h96a};
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // ========================================================
    // design and partner
    fpx_unit i_fpx_unit (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .src_a_data(src_a_data), .src_b_data(src_b_data),
        .busy(busy), .done(done), .wr_en(wr_en), .wr_reg(wr_reg), .wr_double(wr_double),
        .wr_data(wr_data), .exc_taken(exc_taken), .irq(irq));
    fpx_seq_model i_fpx_seq_model (.mclk(mclk), .issue_instr(issue_instr), .wr_en(wr_en),
        .wr_reg(wr_reg), .wr_data(wr_data), .src_a_data(src_a_data), .src_b_data(src_b_data));
    // ========================================================
    // tasks
    function automatic logic [63:0] sg(input logic [31:0] x);
        return {32'h0000_0000, x};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // issue one instruction on r1, r2 and await done
    task automatic op(input logic [4:0] sub, input logic [5:0] prec, input logic [4:0] dst,
        input logic [63:0] a, input logic [63:0] b, input logic [5:0] exc, input logic [63:0] res);
        int n;
        n = 0;
        i_fpx_seq_model.rf[1] = a;
        i_fpx_seq_model.rf[2] = b;
        i_fpx_seq_model.rf[dst] = MARK;
        @(posedge mclk);
        issue_instr <= {FPX_OPC, dst, 5'h01, sub, prec, 5'h02};
        issue_valid <= 1'b1;
        @(posedge mclk);
        issue_valid <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(done, 1'b1);
        check(exc_taken, exc);
        check(wr_en, exc == 6'h00);
        if (exc == 6'h00) check(wr_double, sub != FPX_SUB_CMP && prec[1:0] == PREC_DBL);
        @(posedge mclk);
        #1;
        check(i_fpx_seq_model.rf[dst], exc == 6'h00 ? res : MARK);
    endtask
    // ========================================================
    // watchdog
    initial
    begin
        #100000;
        num_errors++;
        test_done();
    end
    // ========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, issue_valid} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        issue_instr = 32'h0000_0000;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        reg_read(REG_CTRL, 32'h0000_0001);
        reg_read(REG_STAT, 32'h0000_0000);
        reg_read(REG_MASK, 32'h0000_0000);
        reg_write(8'h10, 32'h0000_0000);
        reg_read(8'h10, 32'h0000_0000);
        reg_read(REG_CTRL, 32'h0000_0001);
        op(FPX_SUB_ADD, 6'h00, 5'h03, ONE, TWO, 6'h00, sg(32'h4040_0000));
        op(FPX_SUB_ADD, 6'h11, 5'h03, 64'h3ff0_0000_0000_0000, TWO, 6'h00, 64'h4008_0000_0000_0000);
        op(FPX_SUB_ADD, 6'h01, 5'h03, ONE, TWO, 6'h00, 64'h4008_0000_0000_0000);
        op(FPX_SUB_ADD, 6'h00, 5'h03, ONE, sg(32'h3080_0000), EXC_INX, 64'h0);
        op(FPX_SUB_ADD, 6'h00, 5'h03, sg(32'h7f00_0000), sg(32'h7f00_0000), EXC_OVF, 64'h0);
        op(FPX_SUB_DIV, 6'h00, 5'h03, sg(32'h0080_0000), TWO, EXC_UNF, 64'h0);
        op(FPX_SUB_DIV, 6'h00, 5'h03, ONE, ZRO, EXC_DZ, 64'h0);
        op(FPX_SUB_DIV, 6'h00, 5'h03, ZRO, ZRO, EXC_DZ, 64'h0);
        op(FPX_SUB_DIV, 6'h00, 5'h03, INF, ZRO, EXC_RSV, 64'h0);
        op(FPX_SUB_ADD, 6'h00, 5'h03, INF, ONE, EXC_RSV, 64'h0);
        op(FPX_SUB_CMP, 6'h00, 5'h03, ONE, sg(32'h0000_0001), EXC_RSV, 64'h0);
        op(FPX_SUB_ADD, 6'h00, 5'h00, INF, ONE, EXC_UNIMP, 64'h0);
        op(FPX_SUB_CMP, 6'h01, 5'h03, ONE, TWO, EXC_UNIMP, 64'h0);
        op(FPX_SUB_ADD, 6'h20, 5'h03, ONE, TWO, EXC_UNIMP, 64'h0);
        op(5'h1f, 6'h00, 5'h03, ONE, TWO, EXC_UNIMP, 64'h0);
        for (int i = 0; i < 6; i++)
            op(FPX_SUB_CMP, 6'h00, 5'h03, sg(cmp_a[i]), sg(cmp_b[i]), 6'h00, {52'h0, cmp_f[i]});
        op(FPX_SUB_CMP, 6'h04, 5'h03, ONE, 64'h4000_0000_0000_0000, 6'h00, 64'h66a);
        // inexact masked, then unit disabled
        reg_write(REG_CTRL, 32'h0000_0003);
        op(FPX_SUB_ADD, 6'h00, 5'h03, ONE, sg(32'h3080_0000), 6'h00, ONE);
        reg_write(REG_CTRL, 32'h0000_0000);
        op(FPX_SUB_CMP, 6'h00, 5'h03, ONE, TWO, EXC_UNIMP, 64'h0);
        reg_write(REG_CTRL, 32'h0000_0001);
        // divide, with a second offer ignored while busy
        i_fpx_seq_model.rf[4] = MARK;
        fork
            op(FPX_SUB_DIV, 6'h00, 5'h03, sg(32'h4040_0000), TWO, 6'h00, sg(32'h3fc0_0000));
            begin
                repeat (5) @(posedge mclk);
                issue_instr <= {FPX_OPC, 5'h04, 5'h01, FPX_SUB_CMP, 6'h00, 5'h02};
                issue_valid <= 1'b1;
                @(posedge mclk);
                issue_valid <= 1'b0;
            end
        join
        check(i_fpx_seq_model.rf[4], MARK);
        // sticky status, mask and interrupt level
        check(irq, 1'b0);
        reg_read(REG_STAT, 32'h0000_003f);
        reg_write(REG_STAT, 32'h0000_003f);
        reg_read(REG_STAT, 32'h0000_0000);
        reg_write(REG_MASK, 32'h0000_0001);
        op(FPX_SUB_ADD, 6'h00, 5'h03, INF, ONE, EXC_RSV, 64'h0);
        check(irq, 1'b0);
        op(FPX_SUB_DIV, 6'h00, 5'h00, ONE, ONE, EXC_UNIMP, 64'h0);
        check(irq, 1'b1);
        reg_write(REG_STAT, 32'h0000_0001);
        #1;
        check(irq, 1'b0);
        reg_read(REG_STAT, 32'h0000_0002);
        test_done();
    end
endmodule // testbench
bind fpx_unit fpx_unit_props i_fpx_unit_props (.mclk(mclk), .rst(rst),
    .issue_valid(issue_valid), .issue_instr(issue_instr), .src_b_data(src_b_data), .busy(busy),
    .done(done), .wr_en(wr_en), .wr_double(wr_double), .wr_data(wr_data), .exc_taken(exc_taken));
